//--- uoe_fifo_if.sv
// Carrier between endpoint control and one endpoint packet buffer
`timescale 1ns/100ps
interface uoe_fifo_if #(parameter int DW = 8, parameter int CW = 7);
  logic wr_start;
  logic wr_vld;
  logic [DW-1:0] wr_data;
  logic commit;
  logic crc_in;
  logic pkt_pop;
  logic byte_pop;
  logic [1:0] level;
  logic [CW-1:0] head_cnt;
  logic head_crc;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_start, wr_vld, wr_data, commit, crc_in, pkt_pop, byte_pop,
               input level, head_cnt, head_crc, rd_data);
  modport store (input wr_start, wr_vld, wr_data, commit, crc_in, pkt_pop, byte_pop,
                 output level, head_cnt, head_crc, rd_data);
endinterface

//--- uoe_host_model.sv
// Host-side model that sends OUT data packets into the receive path
`timescale 1ns/100ps
module uoe_host_model (
  // Clock
  input wire logic i_clk,
  // Packet stream towards the endpoint logic
  output logic o_start,
  output logic [1:0] o_ep,
  output logic o_vld,
  output logic [7:0] o_byte,
  output logic o_end,
  output logic o_crc_err,
  output logic o_data1
);
  initial begin
    o_start = 1'b0;
    o_ep = 2'h0;
    o_vld = 1'b0;
    o_byte = 8'hA5;
    o_end = 1'b0;
    o_crc_err = 1'b0;
    o_data1 = 1'b0;
  end
  // one packet per call
  // Gap after each packet is random, so handshakes are waited for slowly or promptly
  task automatic send(input logic [1:0] ep, input int n, input logic d1, input logic crc,
                      input logic [7:0] b [8]);
    int i;
    @(posedge i_clk);
    o_start <= 1'b1;
    o_ep <= ep;
    for (i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_start <= 1'b0;
      o_ep <= ~ep;
      o_vld <= 1'b1;
      o_byte <= b[i];
    end
    @(posedge i_clk);
    o_vld <= 1'b0;
    o_byte <= ~o_byte;
    o_end <= 1'b1;
    o_crc_err <= crc;
    o_data1 <= d1;
    @(posedge i_clk);
    o_end <= 1'b0;
    o_crc_err <= ~crc;
    o_data1 <= ~d1;
    repeat (4 + $urandom % 4) @(posedge i_clk);
  endtask
endmodule // uoe_host_model

//--- uoe_map.svh
// Register map, field positions, reset values and sizes of the OUT endpoint control block
// Overview of operation
// R01 - ISO bit in high control register selects isochronous, else bulk/interrupt mode
// R02 - Bulk and interrupt transfers get identical hardware handling
// R03 - Endpoint event raised when packet-ready is set or a STALL is sent
// R04 - Bulk OUT token plus data sets packet-ready bit 0 and raises event
// R05 - Byte count of the waiting packet shown in high and low count registers
// R06 - Firmware unloads the packet, then clears packet-ready to zero
// R07 - While send-stall bit 5 is set, every bulk OUT gets a STALL
// R08 - Each STALL sent raises an event and sets sent-stall bit 6
// R09 - Sent-stall stays set until firmware writes it to zero
// R10 - Second buffered packet sets packet-ready again right after firmware clears it
// R11 - Host sends one isochronous packet per frame; double buffering advised
// R12 - Isochronous packet is stored, packet-ready set, event raised
// R13 - Isochronous packet with no FIFO room is dropped, overrun bit 2 set
// R14 - Isochronous CRC error packet still stored, data-error bit 3 set
// R15 - Firmware checks data-error each time it unloads an isochronous packet
// R16 - Writing 1 to bit 7 clears data toggle; bit 7 reads zero
// R17 - FIFO-full set at two packets when double buffered, else one
// R18 - Flush write drops next packet, resets pointer, clears packet-ready, self-clears
// R19 - Overrun stays set until firmware clears it; meaningful in isochronous mode
// R20 - Each of the three OUT endpoints keeps its own independent state
// R21 - Low control register bits all reset to zero
`ifndef UOE_MAP_SVH
`define UOE_MAP_SVH
`define UOE_IDX_ADDR 8'h00
`define UOE_CSRL_ADDR 8'h14
`define UOE_CSRH_ADDR 8'h18
`define UOE_CNTL_ADDR 8'h1C
`define UOE_CNTH_ADDR 8'h20
`define UOE_FIFO_ADDR 8'h24
`define UOE_B_OPR 0
`define UOE_B_FULL 1
`define UOE_B_OVR 2
`define UOE_B_DERR 3
`define UOE_B_FLUSH 4
`define UOE_B_SEND_STALL_BIT 5
`define UOE_B_SENT_STALL_FLAG 6
`define UOE_B_CLEAR_TOGGLE_BIT 7
`define UOE_B_ISO 6
`define UOE_B_DBL 7
`define UOE_CSRL_RST 8'h00
`define UOE_CSRH_RST 8'h00
`define UOE_PKT_MAX 64
`endif

//--- uoe_out_ctrl.sv
// OUT endpoints 1-3 control: APB registers, receive decisions, handshakes, events
`timescale 1ns/100ps
`include "uoe_map.svh"
module uoe_out_ctrl import uoe_pkg::*; #(
  parameter int PKT_MAX = `UOE_PKT_MAX
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Receive path from the serial engine
  input wire logic I_RX_START,
  input wire logic [1:0] I_RX_EP,
  input wire logic I_RX_VLD,
  input wire logic [7:0] I_RX_BYTE,
  input wire logic I_RX_END,
  input wire logic I_RX_CRC_ERR,
  input wire logic I_RX_DATA1,
  // Handshake to the serial engine
  output logic O_HS_VLD,
  output logic [1:0] O_HS_CODE,
  // Per-endpoint event pulses and data toggles, bit n is endpoint n
  output logic [3:1] O_EP_OUT_EVENT,
  output logic [3:1] O_EP_TOGGLE
);
  localparam int CW = $clog2(PKT_MAX + 1);

  if (PKT_MAX < 2 || PKT_MAX > 1023) begin : g_bad_cfg
    $error("uoe_out_ctrl: PKT_MAX must be 2 to 1023");
  end

  uoe_rx_state_t state_r;
  uoe_rx_state_t state_nxt;
  logic [1:0] ep_r;
  logic accept_r;
  logic [1:0] idx_r;
  logic [3:1] opr_r;
  logic [3:1] sent_stall_flag_r;
  logic [3:1] send_stall_bit_r;
  logic [3:1] ovr_r;
  logic [3:1] iso_r;
  logic [3:1] dbl_r;
  logic [3:1] tog_r;
  logic [3:1] ev_r;
  logic hs_vld_r;
  uoe_hs_t hs_code_r;
  logic [31:0] prdata_r;
  logic [3:1] end_hit;
  logic [3:1] stall_now;
  logic [3:1] nak_now;
  logic [3:1] ack_now;
  logic [3:1] commit_now;
  logic [3:1] ovr_now;
  logic [3:1] csrl_wr;
  logic [3:1] csrh_wr;
  logic [3:1] opr_clr;
  logic [3:1] flush_now;
  logic [3:1] opr_set;
  logic [3:1] space;
  logic [3:1] full_w;
  logic [7:0] csrl_rd [0:3];
  logic [7:0] csrh_rd [0:3];
  logic [15:0] cnt_rd [0:3];
  logic [7:0] fifo_rd [0:3];
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  uoe_fifo_if #(.DW(8), .CW(CW)) fif [1:3] ();

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);

  // APB decode; zero wait states so every access ends in one access cycle
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  assign mapped = (I_PADDR == `UOE_IDX_ADDR) || (I_PADDR == `UOE_CSRL_ADDR) ||
                  (I_PADDR == `UOE_CSRH_ADDR) || (I_PADDR == `UOE_CNTL_ADDR) ||
                  (I_PADDR == `UOE_CNTH_ADDR) || (I_PADDR == `UOE_FIFO_ADDR);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_PRDATA = prdata_r;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET)
      idx_r <= 2'h0;
    else if (wr_acc && I_PADDR == `UOE_IDX_ADDR)
      idx_r <= I_PWDATA[1:0];
  end

  // Index 0 selects no endpoint and reads as zero
  assign csrl_rd[0] = 8'h00;
  assign csrh_rd[0] = 8'h00;
  assign cnt_rd[0] = 16'h0000;
  assign fifo_rd[0] = 8'h00;

  // Read data is sampled in the setup cycle so it stands from a flop in the access cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET)
      prdata_r <= 32'h0000_0000;
    else if (setup) begin
      case (I_PADDR)
        `UOE_IDX_ADDR: prdata_r <= {30'h0, idx_r};
        `UOE_CSRL_ADDR: prdata_r <= {24'h0, csrl_rd[idx_r]};
        `UOE_CSRH_ADDR: prdata_r <= {24'h0, csrh_rd[idx_r]};
        // R05 packet byte count
        `UOE_CNTL_ADDR: prdata_r <= {24'h0, cnt_rd[idx_r][7:0]};
        `UOE_CNTH_ADDR: prdata_r <= {24'h0, cnt_rd[idx_r][15:8]};
        `UOE_FIFO_ADDR: prdata_r <= {24'h0, fifo_rd[idx_r]};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Receive sequencing; the serial engine is on this clock, so no synchroniser
  always_comb begin
    case (state_r)
      RX_IDLE: state_nxt = (I_RX_START && I_RX_EP != 2'h0) ? RX_DATA : RX_IDLE;
      RX_DATA: state_nxt = I_RX_END ? RX_IDLE : RX_DATA;
      default: state_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET)
      state_r <= RX_IDLE;
    else
      state_r <= state_nxt;
  end

  // Room is judged at packet start; a later unload does not rescue it
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      ep_r <= 2'h0;
      accept_r <= 1'b0;
    end else if (state_r == RX_IDLE && I_RX_START && I_RX_EP != 2'h0) begin
      ep_r <= I_RX_EP;
      accept_r <= space[I_RX_EP];
    end
  end

  // R07 stall answer wins
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      hs_vld_r <= 1'b0;
      hs_code_r <= HS_NONE;
    end else begin
      hs_vld_r <= |(stall_now | nak_now | ack_now);
      if (|stall_now)
        hs_code_r <= HS_STALL;
      else if (|nak_now)
        hs_code_r <= HS_NAK;
      else if (|ack_now)
        hs_code_r <= HS_ACK;
      else
        hs_code_r <= HS_NONE;
    end
  end

  assign O_HS_VLD = hs_vld_r;
  assign O_HS_CODE = hs_code_r;
  assign O_EP_OUT_EVENT = ev_r;
  assign O_EP_TOGGLE = tog_r;

  // R20 per-endpoint copies
  for (genvar e = 1; e <= 3; e++) begin : g_ep
    assign end_hit[e] = (state_r == RX_DATA) && I_RX_END && (ep_r == 2'(e));
    // R02 one path for bulk and interrupt
    assign stall_now[e] = end_hit[e] && !iso_r[e] && send_stall_bit_r[e];
    // Corrupt bulk packets get no ACK or NAK so the host retries; with send-stall set they still get a STALL
    assign nak_now[e] = end_hit[e] && !iso_r[e] && !send_stall_bit_r[e] && !I_RX_CRC_ERR && !accept_r;
    assign ack_now[e] = end_hit[e] && !iso_r[e] && !send_stall_bit_r[e] && !I_RX_CRC_ERR && accept_r;
    // R01 R12 mode steers keeping
    assign commit_now[e] = (ack_now[e] && (I_RX_DATA1 == tog_r[e])) ||
                           (end_hit[e] && iso_r[e] && accept_r);
    // R13 no room drops
    assign ovr_now[e] = end_hit[e] && iso_r[e] && !accept_r;
    assign csrl_wr[e] = wr_acc && I_PADDR == `UOE_CSRL_ADDR && idx_r == 2'(e);
    assign csrh_wr[e] = wr_acc && I_PADDR == `UOE_CSRH_ADDR && idx_r == 2'(e);
    assign opr_clr[e] = csrl_wr[e] && !I_PWDATA[`UOE_B_OPR] && opr_r[e];
    assign flush_now[e] = csrl_wr[e] && I_PWDATA[`UOE_B_FLUSH];
    // R10 rearm from held packet
    assign opr_set[e] = !opr_r[e] && (fif[e].level != 2'h0);
    // R17 full by buffer mode
    assign full_w[e] = (fif[e].level == (dbl_r[e] ? 2'h2 : 2'h1));
    assign space[e] = (fif[e].level < (dbl_r[e] ? 2'h2 : 2'h1));

    assign fif[e].wr_start = (state_r == RX_IDLE) && I_RX_START && (I_RX_EP == 2'(e));
    assign fif[e].wr_vld = (state_r == RX_DATA) && (ep_r == 2'(e)) && accept_r && I_RX_VLD;
    assign fif[e].wr_data = I_RX_BYTE;
    // R14 crc error still kept
    assign fif[e].commit = commit_now[e];
    assign fif[e].crc_in = I_RX_CRC_ERR;
    // R18 flush drops head
    assign fif[e].pkt_pop = (opr_clr[e] || flush_now[e]) && opr_r[e];
    assign fif[e].byte_pop = rd_acc && I_PADDR == `UOE_FIFO_ADDR && idx_r == 2'(e) && opr_r[e];

    // R16 toggle bit reads zero
    assign csrl_rd[e] = {1'b0, sent_stall_flag_r[e], send_stall_bit_r[e], 1'b0, opr_r[e] && fif[e].head_crc,
                         ovr_r[e], full_w[e], opr_r[e]};
    assign csrh_rd[e] = {dbl_r[e], iso_r[e], 6'h00};
    assign cnt_rd[e] = 16'(fif[e].head_cnt);
    assign fifo_rd[e] = fif[e].rd_data;

    uoe_pkt_fifo #(.DW(8), .PKT_MAX(PKT_MAX), .CW(CW)) u_fifo (
      .i_clk(I_CLK_SYS),
      .i_reset(I_RESET),
      .f(fif[e])
    );

    // R21 control bits reset zero
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
        send_stall_bit_r[e] <= 1'(`UOE_CSRL_RST >> `UOE_B_SEND_STALL_BIT);
        iso_r[e] <= 1'b0;
        dbl_r[e] <= 1'b0;
      end else begin
        if (csrl_wr[e])
          send_stall_bit_r[e] <= I_PWDATA[`UOE_B_SEND_STALL_BIT];
        if (csrh_wr[e]) begin
          iso_r[e] <= I_PWDATA[`UOE_B_ISO];
          dbl_r[e] <= I_PWDATA[`UOE_B_DBL];
        end
      end
    end

    // R16 toggle cleared by write
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET)
        tog_r[e] <= 1'b0;
      else if (csrl_wr[e] && I_PWDATA[`UOE_B_CLEAR_TOGGLE_BIT])
        tog_r[e] <= 1'b0;
      else if (commit_now[e] && !iso_r[e])
        tog_r[e] <= ~tog_r[e];
    end

    // R04 packet ready flag
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET)
        opr_r[e] <= 1'b0;
      else if (opr_clr[e] || flush_now[e])
        opr_r[e] <= 1'b0;
      else if (opr_set[e])
        opr_r[e] <= 1'b1;
    end

    // R08 R09 stall sets, sticky until written zero; set beats clear
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
        sent_stall_flag_r[e] <= 1'b0;
        ovr_r[e] <= 1'b0;
      end else begin
        sent_stall_flag_r[e] <= stall_now[e] || (sent_stall_flag_r[e] && !(csrl_wr[e] && !I_PWDATA[`UOE_B_SENT_STALL_FLAG]));
        // R19 overrun held
        ovr_r[e] <= ovr_now[e] || (ovr_r[e] && !(csrl_wr[e] && !I_PWDATA[`UOE_B_OVR]));
      end
    end

    // R03 event sources
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET)
        ev_r[e] <= 1'b0;
      else
        ev_r[e] <= opr_set[e] || stall_now[e] || ovr_now[e];
    end

    AST_STALL_REPLY: assert property (stall_now[e] |=> O_HS_VLD && O_HS_CODE == HS_STALL) // R07
      else $error("stall request not answered with STALL");
    AST_STALL_FLAG: assert property (stall_now[e] |=> sent_stall_flag_r[e] && O_EP_OUT_EVENT[e]) // R08
      else $error("sent-stall flag or event missing after STALL");
    AST_STALL_HOLD: assert property ( // R09
      sent_stall_flag_r[e] && !csrl_wr[e] |=> sent_stall_flag_r[e])
      else $error("sent-stall flag dropped without a write");
    AST_OPR_EVENT: assert property ($rose(opr_r[e]) |-> O_EP_OUT_EVENT[e]) // R03
      else $error("packet-ready set without event");
    AST_BULK_READY: assert property ( // R04
      ack_now[e] && commit_now[e] && fif[e].level == 2'h0 && !opr_r[e] |=> ##1 opr_r[e])
      else $error("bulk packet did not set packet-ready");
    AST_OVERRUN: assert property ( // R13
      ovr_now[e] |=> ovr_r[e] && O_EP_OUT_EVENT[e] && !O_HS_VLD && $stable(fif[e].level))
      else $error("overrun not flagged or packet kept");
    AST_REARM: assert property ( // R10
      opr_clr[e] && fif[e].level == 2'h2 |=> !opr_r[e] ##1 opr_r[e] && O_EP_OUT_EVENT[e])
      else $error("second packet did not rearm packet-ready");
    AST_ISO_CRC: assert property ( // R14
      end_hit[e] && iso_r[e] && accept_r && I_RX_CRC_ERR && fif[e].level == 2'h0
      |=> ##1 opr_r[e] && csrl_rd[e][`UOE_B_DERR])
      else $error("iso CRC packet not stored with data-error");
    AST_FULL_MARK: assert property ( // R17
      commit_now[e] && !fif[e].pkt_pop && fif[e].level == (dbl_r[e] ? 2'h1 : 2'h0)
      |=> full_w[e])
      else $error("FIFO-full not reported");
    AST_TOGGLE_CLR: assert property ( // R16
      csrl_wr[e] && I_PWDATA[`UOE_B_CLEAR_TOGGLE_BIT] |=> !tog_r[e] && !csrl_rd[e][`UOE_B_CLEAR_TOGGLE_BIT])
      else $error("clear-toggle write did not clear toggle");
    AST_FLUSH: assert property ( // R18
      flush_now[e] && opr_r[e] |=> !opr_r[e] && !csrl_rd[e][`UOE_B_FLUSH])
      else $error("flush did not clear packet-ready");
    AST_RESET_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (1'b0) // R21
      $past(I_RESET) |-> csrl_rd[e] == `UOE_CSRL_RST)
      else $error("low control register not zero after reset");

    COV_STALL: cover property (stall_now[e] ##1 O_HS_VLD);
    COV_OVERRUN: cover property (ovr_now[e]);
    COV_REARM: cover property (opr_clr[e] && fif[e].level == 2'h2 ##2 opr_r[e]);
  end

  AST_ONE_HS: assert property ( // R20
    $onehot0(end_hit) && $onehot0(stall_now | nak_now | ack_now))
    else $error("more than one endpoint answered a packet");
endmodule // uoe_out_ctrl

//--- uoe_pkg.sv
// Shared types of the OUT endpoint control block
package uoe_pkg;
  typedef enum logic [1:0] {
    HS_NONE = 2'h0,
    HS_ACK = 2'h1,
    HS_NAK = 2'h2,
    HS_STALL = 2'h3
  } uoe_hs_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'h1,
    RX_DATA = 2'h2
  } uoe_rx_state_t;
endpackage

//--- uoe_pkt_fifo.sv
// Two-slot packet buffer of one OUT endpoint
`timescale 1ns/100ps
module uoe_pkt_fifo import uoe_pkg::*; #(
  parameter int DW = 8,
  parameter int PKT_MAX = 64,
  parameter int CW = 7
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control side
  uoe_fifo_if.store f
);
  localparam int AW = $clog2(PKT_MAX);
  logic [DW-1:0] mem_r [2][PKT_MAX];
  logic [CW-1:0] cnt_r [2];
  logic [1:0] crc_r;
  logic wslot_r;
  logic rslot_r;
  logic [1:0] level_r;
  logic [CW-1:0] wcnt_r;
  logic [CW-1:0] rptr_r;
  logic wr_ok;

  if (PKT_MAX < 2 || CW != $clog2(PKT_MAX + 1)) begin : g_bad_cfg
    $error("uoe_pkt_fifo: CW does not fit PKT_MAX");
  end

  // Oversize packets are clipped rather than wrapping over their own first bytes; a buffer holding two packets takes no writes
  assign wr_ok = f.wr_vld && (wcnt_r < CW'(PKT_MAX)) && (level_r != 2'h2);

  always_ff @(posedge i_clk) begin
    if (wr_ok)
      mem_r[wslot_r][wcnt_r[AW-1:0]] <= f.wr_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || f.wr_start)
      wcnt_r <= '0;
    else if (wr_ok)
      wcnt_r <= wcnt_r + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wslot_r <= 1'b0;
      rslot_r <= 1'b0;
      level_r <= 2'h0;
      crc_r <= 2'h0;
      cnt_r <= '{default: '0};
    end else begin
      if (f.commit) begin
        wslot_r <= ~wslot_r;
        crc_r[wslot_r] <= f.crc_in;
        cnt_r[wslot_r] <= wcnt_r;
      end
      if (f.pkt_pop)
        rslot_r <= ~rslot_r;
      if (f.commit && !f.pkt_pop)
        level_r <= level_r + 2'h1;
      else if (f.pkt_pop && !f.commit)
        level_r <= level_r - 2'h1;
    end
  end

  // R18 flush pointer reset
  always_ff @(posedge i_clk) begin
    if (i_reset || f.pkt_pop)
      rptr_r <= '0;
    else if (f.byte_pop && rptr_r < cnt_r[rslot_r])
      rptr_r <= rptr_r + 1'b1;
  end

  assign f.level = level_r;
  assign f.head_cnt = cnt_r[rslot_r];
  assign f.head_crc = crc_r[rslot_r];
  assign f.rd_data = (rptr_r < cnt_r[rslot_r]) ? mem_r[rslot_r][rptr_r[AW-1:0]] : '0;

  AST_FIFO_LEVEL_MAX: assert property (@(posedge i_clk) disable iff (i_reset) // R17
    level_r != 2'h3)
    else $error("packet buffer holds more than two packets");
endmodule // uoe_pkt_fifo

//--- uoe_tb.sv
// Self-checking testbench of the OUT endpoint control block
`timescale 1ns/100ps
module tb;
  import uoe_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen;
  logic pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, rx_start, rx_vld, rx_end, rx_crc, rx_d1, hs_vld, e;
  logic [1:0] rx_ep, hs_code;
  logic [7:0] rx_byte;
  logic [3:1] ev, tog;
  logic [1:0] hs_q [$];
  logic [3:1] ev_q [$];
  logic [7:0] pb [8];
  logic [31:0] q;
  int fails = 0;
  int cmp_count = 0;
  int n, i;
  always #2 clk_sys = ~clk_sys;
  uoe_out_ctrl #(.PKT_MAX(8)) u_dut (.I_CLK_SYS(clk_sys), .I_RESET(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_START(rx_start), .I_RX_EP(rx_ep),
    .I_RX_VLD(rx_vld), .I_RX_BYTE(rx_byte), .I_RX_END(rx_end), .I_RX_CRC_ERR(rx_crc),
    .I_RX_DATA1(rx_d1), .O_HS_VLD(hs_vld), .O_HS_CODE(hs_code), .O_EP_OUT_EVENT(ev),
    .O_EP_TOGGLE(tog));
  uoe_host_model u_host (.i_clk(clk_sys), .o_start(rx_start), .o_ep(rx_ep), .o_vld(rx_vld),
    .o_byte(rx_byte), .o_end(rx_end), .o_crc_err(rx_crc), .o_data1(rx_d1));
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic err(input string m);
    $display("[ERR] %0t %s", $time, m);
    fails++;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) err($sformatf("register got %0h expected %0h", g, x));
  endtask
  task automatic chk_hs(input logic [1:0] g, input logic [1:0] x);
    cmp_count++;
    if (g !== x) err($sformatf("handshake got %0h expected %0h", g, x));
  endtask
  task automatic chk_ev(input logic [3:1] g, input logic [3:1] x);
    cmp_count++;
    if (g !== x) err($sformatf("event got %0b expected %0b", g, x));
  endtask
  // Zero-wait slave still gets a bounded wait on ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err("bus timeout");
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk_reg(q, x);
  endtask
  task automatic pkt(input logic [1:0] ep, input int len, input logic d1, input logic crc);
    int j;
    for (j = 0; j < 8; j++) pb[j] = 8'($urandom);
    u_host.send(ep, len, d1, crc, pb);
  endtask
  // Results are taken off the queues in the order they were noted
  always @(posedge clk_sys) begin
    if (rst === 1'b0 && hs_vld === 1'b1) begin
      if (hs_q.size() == 0) err("unexpected handshake");
      else chk_hs(hs_code, hs_q.pop_front());
    end
    if (rst === 1'b0 && ev !== 3'b000) begin
      if (ev_q.size() == 0) err("unexpected event");
      else chk_ev(ev, ev_q.pop_front());
    end
  end
  initial begin
    void'($urandom(95947));
    pen <= 1'b0;
    pwr <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'h00, 32'h1);
    rd(8'h14, 32'h00);
    rd(8'h18, 32'h00);
    rd(8'h30, 32'h00);
    chk_reg({31'h0, e}, 32'h1);
    n = 1 + $urandom % 8;
    hs_q.push_back(HS_ACK);
    ev_q.push_back(3'b001);
    pkt(2'h1, n, 1'b0, 1'b0);
    rd(8'h14, 32'h03);
    chk_reg({29'h0, tog}, 32'h1);
    rd(8'h1C, n);
    rd(8'h20, 32'h0);
    for (i = 0; i < n; i++) rd(8'h24, {24'h0, pb[i]});
    hs_q.push_back(HS_NAK);
    pkt(2'h1, 2, 1'b1, 1'b0);
    wr(8'h14, 32'h00);
    rd(8'h14, 32'h00);
    wr(8'h14, 32'h80);
    rd(8'h14, 32'h00);
    chk_reg({29'h0, tog}, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h18, 32'h80);
    hs_q.push_back(HS_ACK);
    ev_q.push_back(3'b010);
    pkt(2'h2, 3, 1'b0, 1'b0);
    hs_q.push_back(HS_ACK);
    pkt(2'h2, 5, 1'b1, 1'b0);
    rd(8'h14, 32'h03);
    rd(8'h1C, 32'h3);
    ev_q.push_back(3'b010);
    wr(8'h14, 32'h00);
    repeat (3) @(posedge clk_sys);
    rd(8'h14, 32'h01);
    rd(8'h1C, 32'h5);
    wr(8'h00, 32'h3);
    wr(8'h14, 32'h20);
    hs_q.push_back(HS_STALL);
    ev_q.push_back(3'b100);
    pkt(2'h3, 2, 1'b0, 1'b0);
    rd(8'h14, 32'h60);
    wr(8'h14, 32'h20);
    rd(8'h14, 32'h20);
    wr(8'h14, 32'h00);
    wr(8'h18, 32'h40);
    ev_q.push_back(3'b100);
    pkt(2'h3, 4, 1'b0, 1'b1);
    rd(8'h14, 32'h0B);
    ev_q.push_back(3'b100);
    pkt(2'h3, 4, 1'b1, 1'b0);
    rd(8'h14, 32'h0F);
    wr(8'h14, 32'h14);
    rd(8'h14, 32'h04);
    repeat (10) @(posedge clk_sys);
    if (hs_q.size() != 0 || ev_q.size() != 0) err("expected result missing");
    conclude();
  end
endmodule // tb
